// [eti_params.svh]
`ifndef ETI_PARAMS_SVH
`define ETI_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ETI_ADDR_EXT_MASK    8'h2C
`define ETI_ADDR_EXT_FLAGS   8'h30
`define ETI_ADDR_TMR_ENABLE  8'h34
`define ETI_ADDR_TMR_FLAGS   8'h38
`define ETI_ADDR_EXT_SENSE   8'h3C
`define ETI_ADDR_PENDING     8'h40

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ETI_BIT_EXT1         7
`define ETI_BIT_EXT0         6
`define ETI_BIT_T1_OVF       7
`define ETI_BIT_CMP_A        6
`define ETI_BIT_CMP_B        5
`define ETI_BIT_CAPTURE      3
`define ETI_BIT_T0_OVF       1
`define ETI_SENSE0_LSB       0
`define ETI_SENSE1_LSB       2

// ----------------------------------------------------------------
// Writable masks and reset values
// ----------------------------------------------------------------
`define ETI_EXT_MASK_BITS    8'hC0
`define ETI_TMR_MASK_BITS    8'hEA
`define ETI_SENSE_BITS       8'h0F
`define ETI_RST_EXT_MASK     8'h00
`define ETI_RST_EXT_FLAGS    8'h00
`define ETI_RST_TMR_ENABLE   8'h00
`define ETI_RST_TMR_FLAGS    8'h00
`define ETI_RST_EXT_SENSE    8'h00

// ----------------------------------------------------------------
// Vector addresses, lowest wins
// ----------------------------------------------------------------
`define ETI_VEC_NONE         4'h0
`define ETI_VEC_EXT0         4'h1
`define ETI_VEC_EXT1         4'h2
`define ETI_VEC_CAPTURE      4'h3
`define ETI_VEC_CMP_A        4'h4
`define ETI_VEC_CMP_B        4'h5
`define ETI_VEC_T1_OVF       4'h6
`define ETI_VEC_T0_OVF       4'h7

`endif

// [eti_pkg.sv]
package eti_pkg;

	// Two-bit sense control per external pin
	typedef enum logic [1:0] {
		ETI_SENSE_LOW  = 2'b00,
		ETI_SENSE_OFF  = 2'b01,
		ETI_SENSE_FALL = 2'b10,
		ETI_SENSE_RISE = 2'b11
	} eti_sense_t;

	typedef logic [3:0]  eti_vec_t;
	typedef logic [7:0]  eti_addr_t;
	typedef logic [31:0] eti_data_t;

endpackage

// [eti_irq_flags.sv]
`timescale 1ns/1ps
`include "eti_params.svh"

// Notes on behaviour
// - Flags set on their event even while the individual enable is clear.
// - Flags stay pending while global enable is clear; served by priority later.
// - Level-sensed external interrupt has no flag; requests only while pin low.
// - Writing one to a clearable flag clears it; writing zero changes nothing.
// - Mask bit 7 enables external interrupt 1 with global enable; vector 2.
// - Mask bit 6 enables external interrupt 0 with global enable; vector 1.
// - Two sense bits per pin select off, rising edge, falling edge or low level.
// - Pin activity is seen even when the pin is driven as an output.
// - Mask bits 5 to 0 are reserved and read zero.
// - Configured edge on external pin 1 sets external flag 1 in bit 7.
// - External 1 vectors when enabled; its flag clears when the vector runs.
// - Writing one clears external flag 1; level sensing holds it cleared.
// - Timer flags in bits 7,6,5,3,1; bits 4,2,0 read zero; reset zero.
// - Timer1 overflow sets its flag; vector or written one clears it.
// - Timer1 overflow requests only with global, enable and flag all set.
// - In PWM mode timer1 direction change at zero sets the overflow flag.
// - Compare A match sets flag; vector or one clears; requests when enabled.
// - Compare B match sets flag; vector or one clears; requests when enabled.
// - Capture transfer sets flag; vector or one clears; requests when enabled.
// - Timer0 overflow sets flag; vector or one clears; requests when enabled.
// - Vector runs at least four cycles after flag; core finishes instruction.
module eti_irq_flags (
	input  wire logic             SYS_CLK,
	input  wire logic             SYS_RST,
	input  wire logic             PSEL,
	input  wire logic             PENABLE,
	input  wire logic             PWRITE,
	input  wire eti_pkg::eti_addr_t PADDR,
	input  wire eti_pkg::eti_data_t PWDATA,
	output eti_pkg::eti_data_t    PRDATA,
	output logic                  PREADY,
	output logic                  PSLVERR,
	input  wire logic             EXT_IRQ0_PIN,
	input  wire logic             EXT_IRQ1_PIN,
	input  wire logic             T1_OVERFLOW,
	input  wire logic             T1_PWM_BOTTOM,
	input  wire logic             CMP_A_MATCH,
	input  wire logic             CMP_B_MATCH,
	input  wire logic             CAPTURE_EVENT,
	input  wire logic             T0_OVERFLOW,
	input  wire logic             GLOBAL_IRQ_EN,
	input  wire logic             VEC_ACK,
	input  wire eti_pkg::eti_vec_t VEC_ACK_NUM,
	output logic                  IRQ_REQ,
	output eti_pkg::eti_vec_t     IRQ_VECTOR
);
	import eti_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0]  ext_irq_mask;
	logic [7:0]  ext_sense;
	logic [7:0]  timer_irq_enable;
	logic [1:0]  ext_flag;
	logic [4:0]  tmr_flag;
	logic [2:0]  sync0;
	logic [2:0]  sync1;
	logic [1:0]  pin_lvl;
	logic [1:0]  pin_rise;
	logic [1:0]  pin_fall;
	logic [1:0]  pin_agree;
	logic [1:0]  pin_new;
	eti_sense_t  sense_mode [2];
	logic [1:0]  level_mode;
	logic [1:0]  edge_hit;
	logic [1:0]  ext_active;
	logic [1:0]  ext_clr;
	logic [4:0]  tmr_set;
	logic [4:0]  tmr_clr;
	logic [4:0]  tmr_en;
	logic [7:0]  tmr_flag_reg;
	logic [7:0]  ext_flag_reg;
	logic [7:0]  pending;
	logic        wr_en;
	logic        rd_setup;
	logic        addr_ok;
	eti_data_t   next_rdata;
	eti_vec_t    next_vector;
	logic        next_req;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Pins are read as inputs only, so a pin driven as an output still
	// triggers here; that is how software raises its own interrupt.
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			sync0 <= 3'h7;
			sync1 <= 3'h7;
		end else begin
			sync0 <= {sync0[1:0], EXT_IRQ0_PIN};
			sync1 <= {sync1[1:0], EXT_IRQ1_PIN};
		end
	end

	// Change counts once the second and third stages agree
	assign pin_agree[0] = (sync0[1] == sync0[2]);
	assign pin_agree[1] = (sync1[1] == sync1[2]);
	assign pin_new[0]   = sync0[2];
	assign pin_new[1]   = sync1[2];

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			pin_lvl <= 2'h3;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (pin_agree[i]) begin
					pin_lvl[i] <= pin_new[i];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Sense decode and external flags
	// ----------------------------------------------------------------
	assign sense_mode[0] = eti_sense_t'(ext_sense[`ETI_SENSE0_LSB +: 2]);
	assign sense_mode[1] = eti_sense_t'(ext_sense[`ETI_SENSE1_LSB +: 2]);

	generate
		for (genvar g = 0; g < 2; g++) begin : g_ext
			assign pin_rise[g]   = pin_agree[g] & pin_new[g] & ~pin_lvl[g];
			assign pin_fall[g]   = pin_agree[g] & ~pin_new[g] & pin_lvl[g];
			assign level_mode[g] = (sense_mode[g] == ETI_SENSE_LOW);
			assign edge_hit[g]   = ((sense_mode[g] == ETI_SENSE_RISE) & pin_rise[g])
				| ((sense_mode[g] == ETI_SENSE_FALL) & pin_fall[g]);
			// No flag in level mode: request follows the pin itself
			assign ext_active[g] = level_mode[g] ? ~pin_lvl[g] : ext_flag[g];
		end
	endgenerate

	assign wr_en    = PSEL & PENABLE & PWRITE & addr_ok;
	assign rd_setup = PSEL & ~PENABLE;

	assign ext_clr[0] = (wr_en & (PADDR == `ETI_ADDR_EXT_FLAGS) & PWDATA[`ETI_BIT_EXT0])
		| (VEC_ACK & (VEC_ACK_NUM == `ETI_VEC_EXT0));
	assign ext_clr[1] = (wr_en & (PADDR == `ETI_ADDR_EXT_FLAGS) & PWDATA[`ETI_BIT_EXT1])
		| (VEC_ACK & (VEC_ACK_NUM == `ETI_VEC_EXT1));

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ext_flag <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (level_mode[i]) begin
					ext_flag[i] <= 1'b0;
				end else if (edge_hit[i]) begin
					ext_flag[i] <= 1'b1;
				end else if (ext_clr[i]) begin
					ext_flag[i] <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Timer flags: index 4 t1 ovf, 3 cmp A, 2 cmp B, 1 capture, 0 t0 ovf
	// ----------------------------------------------------------------
	assign tmr_set[4] = T1_OVERFLOW | T1_PWM_BOTTOM;
	assign tmr_set[3] = CMP_A_MATCH;
	assign tmr_set[2] = CMP_B_MATCH;
	assign tmr_set[1] = CAPTURE_EVENT;
	assign tmr_set[0] = T0_OVERFLOW;

	always_comb begin
		tmr_clr = 5'h00;
		if (wr_en && (PADDR == `ETI_ADDR_TMR_FLAGS)) begin
			tmr_clr = {PWDATA[`ETI_BIT_T1_OVF], PWDATA[`ETI_BIT_CMP_A],
				PWDATA[`ETI_BIT_CMP_B], PWDATA[`ETI_BIT_CAPTURE],
				PWDATA[`ETI_BIT_T0_OVF]};
		end
		if (VEC_ACK) begin
			case (VEC_ACK_NUM)
				`ETI_VEC_T1_OVF:  tmr_clr[4] = 1'b1;
				`ETI_VEC_CMP_A:   tmr_clr[3] = 1'b1;
				`ETI_VEC_CMP_B:   tmr_clr[2] = 1'b1;
				`ETI_VEC_CAPTURE: tmr_clr[1] = 1'b1;
				`ETI_VEC_T0_OVF:  tmr_clr[0] = 1'b1;
				default:          tmr_clr    = tmr_clr;
			endcase
		end
	end

	// Set beats clear so an event in the clearing cycle is kept
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			tmr_flag <= 5'h00;
		end else begin
			tmr_flag <= tmr_set | (tmr_flag & ~tmr_clr);
		end
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ext_irq_mask <= `ETI_RST_EXT_MASK;
		end else if (wr_en && (PADDR == `ETI_ADDR_EXT_MASK)) begin
			ext_irq_mask <= PWDATA[7:0] & `ETI_EXT_MASK_BITS;
		end
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			timer_irq_enable <= `ETI_RST_TMR_ENABLE;
		end else if (wr_en && (PADDR == `ETI_ADDR_TMR_ENABLE)) begin
			timer_irq_enable <= PWDATA[7:0] & `ETI_TMR_MASK_BITS;
		end
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ext_sense <= `ETI_RST_EXT_SENSE;
		end else if (wr_en && (PADDR == `ETI_ADDR_EXT_SENSE)) begin
			ext_sense <= PWDATA[7:0] & `ETI_SENSE_BITS;
		end
	end

	always_comb begin
		tmr_flag_reg = 8'h00;
		tmr_flag_reg[`ETI_BIT_T1_OVF]  = tmr_flag[4];
		tmr_flag_reg[`ETI_BIT_CMP_A]   = tmr_flag[3];
		tmr_flag_reg[`ETI_BIT_CMP_B]   = tmr_flag[2];
		tmr_flag_reg[`ETI_BIT_CAPTURE] = tmr_flag[1];
		tmr_flag_reg[`ETI_BIT_T0_OVF]  = tmr_flag[0];
	end

	always_comb begin
		ext_flag_reg = `ETI_RST_EXT_FLAGS;
		ext_flag_reg[`ETI_BIT_EXT1] = ext_flag[1];
		ext_flag_reg[`ETI_BIT_EXT0] = ext_flag[0];
	end

	assign tmr_en = {timer_irq_enable[`ETI_BIT_T1_OVF], timer_irq_enable[`ETI_BIT_CMP_A],
		timer_irq_enable[`ETI_BIT_CMP_B], timer_irq_enable[`ETI_BIT_CAPTURE],
		timer_irq_enable[`ETI_BIT_T0_OVF]};

	// ----------------------------------------------------------------
	// Request gating and priority
	// ----------------------------------------------------------------
	// Index equals vector address; bit 0 is unused.
	always_comb begin
		pending    = 8'h00;
		pending[1] = ext_active[0] & ext_irq_mask[`ETI_BIT_EXT0];
		pending[2] = ext_active[1] & ext_irq_mask[`ETI_BIT_EXT1];
		pending[3] = tmr_flag[1] & tmr_en[1];
		pending[4] = tmr_flag[3] & tmr_en[3];
		pending[5] = tmr_flag[2] & tmr_en[2];
		pending[6] = tmr_flag[4] & tmr_en[4];
		pending[7] = tmr_flag[0] & tmr_en[0];
	end

	// Global enable gates the request and forces the vector to none; flags wait underneath it
	always_comb begin
		next_req    = GLOBAL_IRQ_EN & (|pending);
		next_vector = `ETI_VEC_NONE;
		for (int i = 7; i >= 1; i--) begin
			if (pending[i]) begin
				next_vector = eti_vec_t'(i);
			end
		end
		if (!GLOBAL_IRQ_EN) begin
			next_vector = `ETI_VEC_NONE;
		end
	end

	// Registered request; core adds its own latency to reach four cycles
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			IRQ_REQ    <= 1'b0;
			IRQ_VECTOR <= `ETI_VEC_NONE;
		end else begin
			IRQ_REQ    <= next_req;
			IRQ_VECTOR <= next_vector;
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	always_comb begin
		case (PADDR)
			`ETI_ADDR_EXT_MASK,
			`ETI_ADDR_EXT_FLAGS,
			`ETI_ADDR_TMR_ENABLE,
			`ETI_ADDR_TMR_FLAGS,
			`ETI_ADDR_EXT_SENSE,
			`ETI_ADDR_PENDING: addr_ok = 1'b1;
			default:           addr_ok = 1'b0;
		endcase
	end

	always_comb begin
		next_rdata = 32'h0000_0000;
		case (PADDR)
			`ETI_ADDR_EXT_MASK:   next_rdata[7:0] = ext_irq_mask;
			`ETI_ADDR_EXT_FLAGS:  next_rdata[7:0] = ext_flag_reg;
			`ETI_ADDR_TMR_ENABLE: next_rdata[7:0] = timer_irq_enable;
			`ETI_ADDR_TMR_FLAGS:  next_rdata[7:0] = tmr_flag_reg;
			`ETI_ADDR_EXT_SENSE:  next_rdata[7:0] = ext_sense;
			`ETI_ADDR_PENDING:    next_rdata[7:0] = pending;
			default:              next_rdata      = 32'h0000_0000;
		endcase
	end

	// Read data caught in the setup cycle, so access needs no wait
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			PRDATA <= 32'h0000_0000;
		end else if (rd_setup) begin
			PRDATA <= next_rdata;
		end
	end

	assign PREADY  = PSEL & PENABLE;
	assign PSLVERR = PSEL & PENABLE & ~addr_ok;

endmodule

// [eti_irq_flags_monitor.sv]
`timescale 1ns/1ps
module eti_irq_flags_monitor (
	input wire logic               SYS_CLK,
	input wire logic               SYS_RST,
	input wire logic               PSEL,
	input wire logic               PENABLE,
	input wire logic               PWRITE,
	input wire eti_pkg::eti_addr_t PADDR,
	input wire eti_pkg::eti_data_t PRDATA,
	input wire logic               GLOBAL_IRQ_EN,
	input wire logic               VEC_ACK,
	input wire eti_pkg::eti_vec_t  VEC_ACK_NUM,
	input wire logic               CMP_A_MATCH,
	input wire logic               T0_OVERFLOW,
	input wire logic               IRQ_REQ,
	input wire eti_pkg::eti_vec_t  IRQ_VECTOR
);
	import eti_pkg::*;
	// --------------------
	// Port relations
	// --------------------
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (SYS_RST);
	wire rd_acc = PSEL && PENABLE && !PWRITE;
	a_mask_rsvd: assert property (rd_acc && PADDR == 8'h2C |-> PRDATA[5:0] == 6'h00)
		else $error("mask reserved bits set");
	a_tmr_rsvd: assert property (rd_acc && PADDR == 8'h38 |-> (PRDATA & 32'h15) == 32'h0)
		else $error("timer flag reserved bits set");
	a_upper_zero: assert property (rd_acc |-> PRDATA[31:8] == 24'h000000)
		else $error("read data upper bits set");
	a_gate_off: assert property (!GLOBAL_IRQ_EN |=> !IRQ_REQ)
		else $error("request without global enable");
	a_rise_gate: assert property ($rose(IRQ_REQ) |-> $past(GLOBAL_IRQ_EN))
		else $error("request rose while gated");
	a_vec_valid: assert property (IRQ_REQ |-> IRQ_VECTOR inside {[4'h1:4'h7]})
		else $error("request without vector");
	a_cmpa_ack: assert property (
		(VEC_ACK && VEC_ACK_NUM == 4'h4 && !CMP_A_MATCH) ##1 !CMP_A_MATCH |=> IRQ_VECTOR != 4'h4)
		else $error("compare A not cleared by ack");
	a_t0_ack: assert property (
		(VEC_ACK && VEC_ACK_NUM == 4'h7) ##0 !T0_OVERFLOW[*2] |=> IRQ_VECTOR != 4'h7)
		else $error("timer0 overflow not cleared by ack");
endmodule

bind eti_irq_flags eti_irq_flags_monitor eti_irq_flags_monitor_inst (.SYS_CLK(SYS_CLK),
	.SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
	.PRDATA(PRDATA), .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .VEC_ACK(VEC_ACK), .VEC_ACK_NUM(VEC_ACK_NUM),
	.CMP_A_MATCH(CMP_A_MATCH), .T0_OVERFLOW(T0_OVERFLOW), .IRQ_REQ(IRQ_REQ),
	.IRQ_VECTOR(IRQ_VECTOR));

// [eti_core_model.sv]
`timescale 1ns/1ps
module eti_core_model (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              irq_req,
	input  wire eti_pkg::eti_vec_t irq_vector,
	input  wire logic              enable_in,
	input  wire logic [3:0]        wait_cycles,
	output logic                   global_en,
	output logic                   vec_ack,
	output eti_pkg::eti_vec_t      vec_ack_num
);
	import eti_pkg::*;
	logic [3:0] cnt;
	logic [2:0] hold;
	assign global_en = enable_in;
	// --------------------
	// Vector fetch
	// --------------------
	// Hold-off covers the two-edge lag before the request drops
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{cnt, hold, vec_ack, vec_ack_num} <= 12'h000;
		end else begin
			vec_ack <= 1'b0;
			vec_ack_num <= ~vec_ack_num;
			cnt <= 4'h0;
			if (hold != 3'h0) begin
				hold <= hold - 3'h1;
			end else if (irq_req && global_en) begin
				cnt <= cnt + 4'h1;
				// Two counts after the registered request keep four cycles from the flag
				if (cnt >= wait_cycles && cnt >= 4'h2) begin
					vec_ack <= 1'b1;
					vec_ack_num <= irq_vector;
					hold <= 3'h4;
				end
			end
		end
	end
endmodule

// [tb.sv]
`timescale 1ns/1ps
`include "eti_params.svh"
module tb;
	import eti_pkg::*;
	logic       SYS_CLK, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, slv, ie;
	logic       EXT_IRQ0_PIN, EXT_IRQ1_PIN, GLOBAL_IRQ_EN, VEC_ACK, IRQ_REQ;
	logic [5:0] ev;
	logic [3:0] wc;
	eti_addr_t  PADDR;
	eti_data_t  PWDATA, PRDATA, rd;
	eti_vec_t   VEC_ACK_NUM, IRQ_VECTOR;
	int         err_count, tests_run;
	int         bits [6] = '{7, 7, 6, 5, 3, 1};
	localparam eti_addr_t tf = `ETI_ADDR_TMR_FLAGS;
	localparam eti_addr_t ef = `ETI_ADDR_EXT_FLAGS;

	eti_irq_flags eti_irq_flags_inst (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .EXT_IRQ0_PIN(EXT_IRQ0_PIN),
		.EXT_IRQ1_PIN(EXT_IRQ1_PIN), .T1_OVERFLOW(ev[0]), .T1_PWM_BOTTOM(ev[1]),
		.CMP_A_MATCH(ev[2]), .CMP_B_MATCH(ev[3]), .CAPTURE_EVENT(ev[4]), .T0_OVERFLOW(ev[5]),
		.GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .VEC_ACK(VEC_ACK), .VEC_ACK_NUM(VEC_ACK_NUM),
		.IRQ_REQ(IRQ_REQ), .IRQ_VECTOR(IRQ_VECTOR));
	eti_core_model eti_core_model_inst (.clk(SYS_CLK), .rst(SYS_RST), .irq_req(IRQ_REQ),
		.irq_vector(IRQ_VECTOR), .enable_in(ie), .wait_cycles(wc), .global_en(GLOBAL_IRQ_EN),
		.vec_ack(VEC_ACK), .vec_ack_num(VEC_ACK_NUM));

	initial begin
		SYS_CLK = 1'b0;
		forever #50 SYS_CLK = ~SYS_CLK;
	end
	// --------------------
	// Helpers
	// --------------------
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task end_sim;
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task wait_hi(input bit ack);
		int n;
		n = 0;
		do begin
			@(posedge SYS_CLK);
			n++;
		end while ((ack ? VEC_ACK : PREADY) !== 1'b1 && n < 60);
		if ((ack ? VEC_ACK : PREADY) !== 1'b1) begin
			err_count++;
			end_sim;
		end
	endtask
	task apb(input logic w, input eti_addr_t a, input logic [7:0] d);
		@(posedge SYS_CLK);
		{PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, 24'h000000, d};
		@(posedge SYS_CLK);
		PENABLE <= 1'b1;
		wait_hi(1'b0);
		{slv, rd} = {PSLVERR, PRDATA};
		{PSEL, PENABLE} <= 2'h0;
	endtask
	task rchk(input string nm, input eti_addr_t a, input logic [31:0] exp);
		apb(1'b0, a, 8'h00);
		check(nm, rd, exp);
	endtask
	task ack_chk(input string nm, input logic [31:0] exp);
		wait_hi(1'b1);
		check(nm, {28'h0000000, VEC_ACK_NUM}, exp);
	endtask
	task pulse(input int i);
		@(posedge SYS_CLK);
		ev[i] <= 1'b1;
		@(posedge SYS_CLK);
		ev <= 6'h00;
	endtask
	// --------------------
	// Scenarios
	// --------------------
	task s_regs;
		rchk("timer flags reset", tf, 32'h0);
		apb(1'b1, `ETI_ADDR_EXT_MASK, 8'hFF);
		rchk("mask", `ETI_ADDR_EXT_MASK, 32'hC0);
		apb(1'b1, tf, 8'hFF);
		rchk("timer flags fixed", tf, 32'h0);
		apb(1'b0, 8'h50, 8'h00);
		check("unmapped", {31'h0, slv}, 32'h1);
		check("unmapped data", rd, 32'h0);
		apb(1'b1, `ETI_ADDR_EXT_MASK, 8'h00);
	endtask
	task s_timer;
		for (int i = 0; i < 6; i++) begin
			pulse(i);
			rchk("flag set", tf, 32'h1 << bits[i]);
			apb(1'b1, tf, 8'h00);
			rchk("zero write", tf, 32'h1 << bits[i]);
			apb(1'b1, tf, 8'hFF);
			rchk("one write", tf, 32'h0);
		end
	endtask
	task s_prio;
		apb(1'b1, `ETI_ADDR_TMR_ENABLE, 8'hEA);
		rchk("timer enables", `ETI_ADDR_TMR_ENABLE, 32'hEA);
		wc <= 4'h6;
		for (int i = 0; i < 6; i++) pulse(i);
		repeat (4) @(posedge SYS_CLK);
		check("gated", {31'h0, IRQ_REQ}, 32'h0);
		rchk("pending", `ETI_ADDR_PENDING, 32'hF8);
		ie <= 1'b1;
		for (int v = 3; v < 8; v++) ack_chk("order", v);
		rchk("acked", tf, 32'h0);
		check("drained", {31'h0, IRQ_REQ}, 32'h0);
		{ie, wc} <= 5'h00;
	endtask
	task s_ext;
		apb(1'b1, `ETI_ADDR_EXT_SENSE, 8'h0E);
		EXT_IRQ1_PIN <= 1'b0;
		repeat (6) @(posedge SYS_CLK);
		{EXT_IRQ1_PIN, EXT_IRQ0_PIN} <= 2'h2;
		repeat (6) @(posedge SYS_CLK);
		rchk("edge flags", ef, 32'hC0);
		apb(1'b1, ef, 8'h80);
		rchk("ext1 cleared", ef, 32'h40);
		apb(1'b1, `ETI_ADDR_EXT_MASK, 8'hC0);
		ie <= 1'b1;
		ack_chk("ext0 vector", 32'h1);
		EXT_IRQ1_PIN <= 1'b0;
		repeat (6) @(posedge SYS_CLK);
		EXT_IRQ1_PIN <= 1'b1;
		ack_chk("ext1 vector", 32'h2);
		rchk("ext acked", ef, 32'h0);
		apb(1'b1, `ETI_ADDR_EXT_SENSE, 8'h0C);
		ack_chk("level vector", 32'h1);
		rchk("no level flag", ef, 32'h0);
		EXT_IRQ0_PIN <= 1'b1;
		repeat (8) @(posedge SYS_CLK);
		check("level gone", {31'h0, IRQ_REQ}, 32'h0);
	endtask

	initial begin
		{SYS_RST, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = {4'h8, 40'h0000000000};
		{EXT_IRQ0_PIN, EXT_IRQ1_PIN, ev, ie, wc} = 13'h1800;
		{err_count, tests_run} = 64'h0;
		repeat (3) @(posedge SYS_CLK);
		SYS_RST <= 1'b0;
		s_regs;
		s_timer;
		s_prio;
		s_ext;
		end_sim;
	end
endmodule
